// *** src/splc_top.sv ***
// Stack pointer, limit register and stack error trap for a 16-bit core.
// Assumes the core pulses one push or pop per cycle, presents addresses
// formed with the pointer on the check port, and acknowledges traps.
`include "splc_consts.svh"

module splc_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic                  CLK_I,
  input  wire logic                  RSTN_I,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]     AWADDR_I,
  input  wire logic                  AWVALID_I,
  output logic                       AWREADY_O,
  input  wire logic [31:0]           WDATA_I,
  input  wire logic [3:0]            WSTRB_I,
  input  wire logic                  WVALID_I,
  output logic                       WREADY_O,
  output logic [1:0]                 BRESP_O,
  output logic                       BVALID_O,
  input  wire logic                  BREADY_I,
  input  wire logic [ADDR_W-1:0]     ARADDR_I,
  input  wire logic                  ARVALID_I,
  output logic                       ARREADY_O,
  output logic [31:0]                RDATA_O,
  output logic [1:0]                 RRESP_O,
  output logic                       RVALID_O,
  input  wire logic                  RREADY_I,
  // Core side
  input  wire splc_pkg::splc_stk_req_s STK_REQ_I,
  input  wire logic                  SP_LOAD_I,
  input  wire logic [15:0]           SP_LOAD_DATA_I,
  input  wire logic                  EA_VALID_I,
  input  wire logic [15:0]           EA_I,
  output splc_pkg::splc_mem_req_s    MEM_REQ_O,
  output logic [15:0]                SP_O,
  output logic                       TRAP_REQ_O,
  output splc_pkg::splc_err_t        TRAP_CAUSE_O,
  input  wire logic                  TRAP_ACK_I,
  output logic                       IRQ_O
);

  // -------------------------------------------------------------------
  // Parameter check
  // -------------------------------------------------------------------
  // Highest index 0x43 needs byte address 0x10C
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
    $error("splc_top: ADDR_W must be 9 to 32");
  end

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  // Word index from a byte address
  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    return 8'(32'(a) >> 2);
  endfunction : word_idx
  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
    return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // Errors of one address against limit and floor
  function automatic splc_pkg::splc_err_t check_addr(
      input logic [15:0] a, input logic [15:0] lim, input logic lim_ok);
    splc_pkg::splc_err_t e;
    e = '0;
    e[`SPLC_BIT_OVF] = lim_ok && (a > lim);
    e[`SPLC_BIT_UNF] = (a < `SPLC_FLOOR);
    return e;
  endfunction : check_addr

  // -------------------------------------------------------------------
  // AXI4-Lite write channel
  // -------------------------------------------------------------------
  logic              aw_have_q, aw_have_d;
  logic [7:0]        aw_idx_q, aw_idx_d;
  logic              w_have_q, w_have_d;
  logic [31:0]       w_data_q, w_data_d;
  logic [3:0]        w_strb_q, w_strb_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              wr_fire;
  logic              wr_hit;

  assign AWREADY_O = !aw_have_q && !bvalid_q;
  assign WREADY_O  = !w_have_q && !bvalid_q;
  assign wr_fire   = aw_have_q && w_have_q && !bvalid_q;
  assign BVALID_O  = bvalid_q;
  assign BRESP_O   = bresp_q;

  // Address and data taken in either order, answered once both are in
  always_comb begin
    aw_have_d = aw_have_q;
    aw_idx_d  = aw_idx_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (AWVALID_I && AWREADY_O) begin
      aw_have_d = 1'b1;
      aw_idx_d  = word_idx(AWADDR_I);
    end
    if (WVALID_I && WREADY_O) begin
      w_have_d = 1'b1;
      w_data_d = WDATA_I;
      w_strb_d = WSTRB_I;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? `SPLC_RESP_OKAY : `SPLC_RESP_SLVERR;
    end else if (bvalid_q && BREADY_I) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SPLC_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_idx_q  <= aw_idx_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end
  // Register write strobes; any other index answers with an error
  logic wr_sp, wr_lim, wr_clr, wr_en;
  assign wr_sp  = wr_fire && (aw_idx_q == `SPLC_IDX_SP);
  assign wr_lim = wr_fire && (aw_idx_q == `SPLC_IDX_LIMIT);
  assign wr_clr = wr_fire && (aw_idx_q == `SPLC_IDX_INT_CLR);
  assign wr_en  = wr_fire && (aw_idx_q == `SPLC_IDX_INT_EN);
  assign wr_hit = wr_sp || wr_lim || wr_clr || wr_en;

  // -------------------------------------------------------------------
  // Limit register
  // -------------------------------------------------------------------
  // No reset on the value itself; a valid flag keeps the overflow
  // compare and the read port quiet until software has loaded it.
  logic [15:0] lim_q, lim_d;
  logic        lim_ok_q, lim_ok_d;
  always_comb begin
    lim_d    = lim_q;
    lim_ok_d = lim_ok_q;
    if (wr_lim) begin
      lim_d    = merge16(lim_q, w_data_q, w_strb_q);
      lim_d[0] = 1'b0;
      lim_ok_d = 1'b1;
    end
  end

  // Value flop without reset: contents undefined until written
  always_ff @(posedge CLK_I) begin
    lim_q <= lim_d;
  end

  // New limit is compared from the next cycle on
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      lim_ok_q <= 1'b0;
    end else begin
      lim_ok_q <= lim_ok_d;
    end
  end

  // -------------------------------------------------------------------
  // Stack pointer and stack memory requests
  // -------------------------------------------------------------------
  logic [15:0]             sp_q, sp_d;
  splc_pkg::splc_mem_req_s mem_q, mem_d;
  splc_pkg::splc_err_t     op_err;
  logic                    op_chk;
  logic [15:0]             op_addr;
  // Core load beats push, push beats pop, bus write comes last
  always_comb begin
    sp_d    = sp_q;
    mem_d   = '0;
    op_chk  = 1'b0;
    op_addr = sp_q;
    if (SP_LOAD_I) begin
      sp_d    = {SP_LOAD_DATA_I[15:1], 1'b0};
      op_chk  = 1'b1;
      op_addr = sp_d;
    end else if (STK_REQ_I.push) begin
      mem_d.we   = 1'b1;
      mem_d.addr = sp_q;
      sp_d       = sp_q + `SPLC_STEP;
      op_chk     = 1'b1;
      op_addr    = sp_q;
      case (STK_REQ_I.kind)
        splc_pkg::SPLC_PUSH_CALL:
          mem_d.wdata = {8'h00, STK_REQ_I.wdata[7:0]};
        splc_pkg::SPLC_PUSH_EXC:
          mem_d.wdata = {STK_REQ_I.status_low_byte, STK_REQ_I.wdata[7:0]};
        default: mem_d.wdata = STK_REQ_I.wdata;
      endcase
    end else if (STK_REQ_I.pop) begin
      sp_d       = sp_q - `SPLC_STEP;
      mem_d.re   = 1'b1;
      mem_d.addr = sp_d;
      op_chk     = 1'b1;
      op_addr    = sp_d;
    end else if (wr_sp) begin
      sp_d    = merge16(sp_q, w_data_q, w_strb_q);
      sp_d[0] = 1'b0;
      op_chk  = 1'b1;
      op_addr = sp_d;
    end
  end

  // Errors of the own stack operation or pointer load
  assign op_err = op_chk ? check_addr(op_addr, lim_q, lim_ok_q) : '0;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sp_q  <= `SPLC_RST_SP;
      mem_q <= '0;
    end else begin
      sp_q  <= sp_d;
      mem_q <= mem_d;
    end
  end
  assign SP_O      = sp_q;
  assign MEM_REQ_O = mem_q;

  // -------------------------------------------------------------------
  // Effective address check
  // -------------------------------------------------------------------
  // Addresses the core forms itself with the pointer as base
  splc_pkg::splc_err_t ea_err;
  splc_pkg::splc_err_t new_err;
  assign ea_err  = EA_VALID_I ? check_addr(EA_I, lim_q, lim_ok_q)
                              : '0;
  assign new_err = ea_err | op_err;

  // -------------------------------------------------------------------
  // Trap request
  // -------------------------------------------------------------------
  logic                trap_q, trap_d;
  splc_pkg::splc_err_t cause_q, cause_d;
  // A fresh error in the acknowledge cycle keeps the request standing
  always_comb begin
    trap_d  = trap_q;
    cause_d = cause_q;
    if (TRAP_ACK_I && trap_q) begin
      trap_d  = 1'b0;
      cause_d = '0;
    end
    if (|new_err) begin
      trap_d  = 1'b1;
      cause_d = cause_d | new_err;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      trap_q  <= 1'b0;
      cause_q <= '0;
    end else begin
      trap_q  <= trap_d;
      cause_q <= cause_d;
    end
  end
  assign TRAP_REQ_O   = trap_q;
  assign TRAP_CAUSE_O = cause_q;

  // -------------------------------------------------------------------
  // Interrupt status, clear and enable
  // -------------------------------------------------------------------
  splc_pkg::splc_err_t ist_q, ist_d;
  splc_pkg::splc_err_t ien_q, ien_d;
  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    ist_d = ist_q & ~((wr_clr && w_strb_q[0]) ? w_data_q[1:0] : 2'h0);
    ist_d = ist_d | new_err;
    ien_d = (wr_en && w_strb_q[0]) ? w_data_q[1:0] : ien_q;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ist_q <= '0;
      ien_q <= `SPLC_RST_INT_EN;
    end else begin
      ist_q <= ist_d;
      ien_q <= ien_d;
    end
  end
  assign IRQ_O = |(ist_q & ien_q);

  // -------------------------------------------------------------------
  // AXI4-Lite read channel
  // -------------------------------------------------------------------
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [7:0]  rd_idx;
  logic [15:0] rd_val;
  logic        rd_hit;
  assign ARREADY_O = !rvalid_q;
  assign rd_idx    = word_idx(ARADDR_I);

  // Read decode; write-only clear reads zero
  always_comb begin
    rd_hit = 1'b1;
    if (rd_idx == `SPLC_IDX_SP) begin
      rd_val = sp_q;
    end else if (rd_idx == `SPLC_IDX_LIMIT) begin
      rd_val = lim_ok_q ? lim_q : `SPLC_RST_LIMIT;
    end else if (rd_idx == `SPLC_IDX_INT_STAT) begin
      rd_val = {14'h0000, ist_q};
    end else if (rd_idx == `SPLC_IDX_INT_CLR) begin
      rd_val = 16'h0000;
    end else if (rd_idx == `SPLC_IDX_INT_EN) begin
      rd_val = {14'h0000, ien_q};
    end else if (rd_idx == `SPLC_IDX_TRAP) begin
      rd_val = {trap_q, 13'h0000, cause_q};
    end else begin
      rd_val = 16'h0000;
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ARVALID_I && ARREADY_O) begin
      rvalid_d = 1'b1;
      rdata_d  = {16'h0000, rd_val};
      rresp_d  = rd_hit ? `SPLC_RESP_OKAY : `SPLC_RESP_SLVERR;
    end else if (rvalid_q && RREADY_I) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `SPLC_RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end
  assign RVALID_O = rvalid_q;
  assign RDATA_O  = rdata_q;
  assign RRESP_O  = rresp_q;

endmodule : splc_top

// *** shared/splc_consts.svh ***
// Constants of the stack pointer limit checker: offsets, resets, floor, fields.
// Assumes a 16-bit word data space and AXI4-Lite register access.
//
// Function
// - Working register fifteen is the pointer for every hardware stack op.
// - Pointer always addresses next unused word; stack grows upward.
// - Push writes then increments; pop decrements then reads.
// - Call push stores upper PC word with clear high byte.
// - Exception push puts status low byte in upper PC word high byte.
// - Limit register bit 0 reads zero and ignores writes.
// - Limit register is not initialised at reset; undefined until written (here it reads 0000h and is not compared until then).
// - Each address formed from the pointer is compared with the limit.
// - Push at pointer equal to limit passes; the next push traps.
// - Pointer address below the fixed floor raises an underflow trap.
`ifndef SPLC_CONSTS_SVH
`define SPLC_CONSTS_SVH

// Printed offsets are word indices; byte address is four times the index
`define SPLC_IDX_SP        8'h1E
`define SPLC_IDX_LIMIT     8'h20
`define SPLC_IDX_INT_STAT  8'h40
`define SPLC_IDX_INT_CLR   8'h41
`define SPLC_IDX_INT_EN    8'h42
`define SPLC_IDX_TRAP      8'h43

// Reset values
`define SPLC_RST_SP        16'h0800
`define SPLC_RST_LIMIT     16'h0000
`define SPLC_RST_INT_EN    2'h0

// Fixed floor that keeps the stack out of special register space
`define SPLC_FLOOR         16'h0800

// Field positions of status, clear, enable and trap cause
`define SPLC_BIT_OVF       0
`define SPLC_BIT_UNF       1

// Stack step in bytes (one word)
`define SPLC_STEP          16'h0002

// AXI responses
`define SPLC_RESP_OKAY     2'h0
`define SPLC_RESP_SLVERR   2'h2

`endif

// *** shared/splc_pkg.sv ***
// Types of the stack pointer limit checker.
// Assumes splc_consts.svh supplies the numeric constants.
package splc_pkg;

  // Kind of word being pushed
  typedef enum logic [1:0] {
    SPLC_PUSH_DATA = 2'b00,
    SPLC_PUSH_CALL = 2'b01,
    SPLC_PUSH_EXC  = 2'b10
  } splc_kind_e;

  // Stack request from the core's address generation
  typedef struct packed {
    logic       push;
    logic       pop;
    splc_kind_e kind;
    logic [15:0] wdata;
    logic [7:0] status_low_byte;
  } splc_stk_req_s;

  // Data memory access issued for a stack operation
  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [15:0] wdata;
  } splc_mem_req_s;

  // Error pair: overflow in bit 0, underflow in bit 1
  typedef logic [1:0] splc_err_t;

endpackage : splc_pkg

// *** testbench/splc_checker.sv ***
// Concurrent checks on the stack checker's core-side ports.
// Assumes binding to splc_top; sees its ports only.
`include "splc_consts.svh"
// ---------------------------------------------------------------
// Checker
// ---------------------------------------------------------------
module splc_checker (
  input wire logic                    CLK_I,
  input wire logic                    RSTN_I,
  input wire splc_pkg::splc_stk_req_s STK_REQ_I,
  input wire logic                    SP_LOAD_I,
  input wire logic                    EA_VALID_I,
  input wire logic [15:0]             EA_I,
  input wire splc_pkg::splc_mem_req_s MEM_REQ_O,
  input wire logic [15:0]             SP_O,
  input wire logic                    TRAP_REQ_O,
  input wire splc_pkg::splc_err_t     TRAP_CAUSE_O,
  input wire logic                    TRAP_ACK_I
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic psh;
  logic pop;
  // Load wins over push, push over pop
  assign psh = STK_REQ_I.push && !SP_LOAD_I;
  assign pop = STK_REQ_I.pop && !STK_REQ_I.push && !SP_LOAD_I;

  a_push_post_inc: assert property (
    psh |=> MEM_REQ_O.we && MEM_REQ_O.addr == $past(SP_O)
            && SP_O == $past(SP_O) + `SPLC_STEP)
    else $error("push not write then increment");
  a_pop_pre_dec: assert property (
    pop |=> MEM_REQ_O.re && SP_O == $past(SP_O) - `SPLC_STEP
            && MEM_REQ_O.addr == SP_O)
    else $error("pop not decrement then read");
  a_call_zero_ext: assert property (
    psh && STK_REQ_I.kind == splc_pkg::SPLC_PUSH_CALL
    |=> MEM_REQ_O.wdata == {8'h00, $past(STK_REQ_I.wdata[7:0])})
    else $error("call push high byte not clear");
  a_exc_status_byte: assert property (
    psh && STK_REQ_I.kind == splc_pkg::SPLC_PUSH_EXC
    |=> MEM_REQ_O.wdata ==
        {$past(STK_REQ_I.status_low_byte), $past(STK_REQ_I.wdata[7:0])})
    else $error("exception push lacks status byte");
  a_ea_underflow: assert property (
    EA_VALID_I && EA_I < `SPLC_FLOOR
    |=> TRAP_REQ_O && TRAP_CAUSE_O[`SPLC_BIT_UNF])
    else $error("address below floor not trapped");
  a_trap_held: assert property (
    TRAP_REQ_O && !TRAP_ACK_I |=> TRAP_REQ_O)
    else $error("trap dropped before acknowledge");
  a_trap_cause: assert property (
    $rose(TRAP_REQ_O) |-> TRAP_CAUSE_O != 2'h0)
    else $error("trap raised without cause");
  a_sp_aligned: assert property (
    !SP_O[0])
    else $error("pointer not word aligned");
endmodule : splc_checker

bind splc_top splc_checker chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
  .STK_REQ_I(STK_REQ_I), .SP_LOAD_I(SP_LOAD_I), .EA_VALID_I(EA_VALID_I),
  .EA_I(EA_I), .MEM_REQ_O(MEM_REQ_O), .SP_O(SP_O),
  .TRAP_REQ_O(TRAP_REQ_O), .TRAP_CAUSE_O(TRAP_CAUSE_O),
  .TRAP_ACK_I(TRAP_ACK_I));

// *** testbench/splc_core_model.sv ***
// Model of the core's address generation and exception logic.
// Assumes the bench calls op() and sets the trap acknowledge delay.
// ---------------------------------------------------------------
// Core model
// ---------------------------------------------------------------
module splc_core_model (
  input  wire logic               clk_i,
  input  wire logic               trap_req_i,
  input  wire logic [3:0]         ack_wait_i,
  output splc_pkg::splc_stk_req_s stk_req_o,
  output logic                    sp_load_o,
  output logic [15:0]             sp_load_data_o,
  output logic                    ea_valid_o,
  output logic [15:0]             ea_o,
  output logic                    trap_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // Idle values at time zero
  initial begin
    stk_req_o = '0;
    {sp_load_o, sp_load_data_o, ea_valid_o, ea_o} = '0;
    {trap_ack_o, cnt} = '0;
  end
  // One request: t 0-2 push of that kind, 3 pop, 4 load, 5 check.
  // Released data is inverted so a stale value is never trusted.
  task automatic op(input int t, input logic [15:0] d,
                    input logic [7:0] s);
    @(posedge clk_i);
    stk_req_o <= '{t < 3, t == 3,
                   splc_pkg::splc_kind_e'(t < 3 ? t[1:0] : 2'h0), d, s};
    sp_load_o <= (t == 4);
    ea_valid_o <= (t == 5);
    sp_load_data_o <= d;
    ea_o <= d;
    @(posedge clk_i);
    stk_req_o <= '{1'b0, 1'b0, splc_pkg::SPLC_PUSH_DATA, ~d, ~s};
    {sp_load_o, ea_valid_o} <= 2'h0;
    sp_load_data_o <= ~d;
    ea_o <= ~d;
  endtask : op
  // Acknowledge after ack_wait_i cycles; a slow setting tests the hold
  always @(posedge clk_i) begin
    if (!trap_req_i || trap_ack_o) begin
      cnt <= 4'h0;
      trap_ack_o <= 1'b0;
    end else if (cnt >= ack_wait_i) trap_ack_o <= 1'b1;
    else cnt <= cnt + 4'h1;
  end
endmodule : splc_core_model

// *** testbench/tb_top.sv ***
// Self-checking bench: reference pointer model against splc_top.
// Assumes the checker is bound and the core model drives the core side.
`include "splc_consts.svh"
// ---------------------------------------------------------------
// Bench top
// ---------------------------------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0, aw = '0;
  logic [1:0]  bresp, rresp, cause;
  logic [15:0] ldd, ea, spo;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        ld, eav, trap, ack, irq;
  splc_pkg::splc_stk_req_s stk;
  splc_pkg::splc_mem_req_s mreq;
  int          sp, lim, errors = 0, checked = 0, cyc = 0;
  bit          lim_ok;

  splc_top uut (.CLK_I(clk), .RSTN_I(rstn), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
    .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
    .RREADY_I(rready), .STK_REQ_I(stk), .SP_LOAD_I(ld),
    .SP_LOAD_DATA_I(ldd), .EA_VALID_I(eav), .EA_I(ea), .MEM_REQ_O(mreq),
    .SP_O(spo), .TRAP_REQ_O(trap), .TRAP_CAUSE_O(cause),
    .TRAP_ACK_I(ack), .IRQ_O(irq));
  splc_core_model core (.clk_i(clk), .trap_req_i(trap), .ack_wait_i(aw),
    .stk_req_o(stk), .sp_load_o(ld), .sp_load_data_o(ldd),
    .ea_valid_o(eav), .ea_o(ea), .trap_ack_o(ack));

  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      results();
    end
  end

  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : cmp

  task automatic results;
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // One register access; w selects write, er is the expected response
  task automatic bus(input bit w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic [1:0] er);
    bit ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    if (w) begin
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid, bready} <= 3'h7;
      while (!(ta && tw)) begin
        @(posedge clk);
        if (!ta && awready) begin ta = 1'b1; awvalid <= 1'b0; end
        if (!tw && wready) begin tw = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge clk); while (!bvalid);
      bready <= 1'b0;
      cmp("bresp", er, bresp);
    end else begin
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
      cmp("rresp", er, rresp);
      cmp("rdata", e, rdata);
    end
  endtask : bus

  // Core operation against the reference pointer model
  task automatic step(input int t, input logic [15:0] d,
                      input logic [7:0] s);
    int a;
    bit e;
    logic [15:0] w;
    case (t)
      3: begin sp -= 2; a = sp; end
      4: begin sp = d & 16'hFFFE; a = sp; end
      5: a = d;
      default: begin a = sp; sp += 2; end
    endcase
    w = (t == 1) ? {8'h00, d[7:0]} : (t == 2) ? {s, d[7:0]} : d;
    e = (a < 'h800) || (lim_ok && a > lim);
    core.op(t, d, s);
    #1;
    if (t < 4) cmp("mem_addr", a, mreq.addr);
    if (t < 4) cmp("mem_we", t < 3, mreq.we);
    if (t < 4) cmp("mem_re", t == 3, mreq.re);
    if (t < 3) cmp("mem_wdata", w, mreq.wdata);
    cmp("sp", sp, spo);
    cmp("trap", e, trap);
    if (e) cmp("cause", 1, cause[a < 'h800]);
    while (trap) @(posedge clk) #1;
  endtask : step

  // Main sequence
  initial begin
    void'($urandom(54));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    sp = 'h800;
    lim_ok = 1'b0;
    bus(0, 12'h078, 0, 'h800, 0);
    bus(0, 12'h080, 0, 0, 0);
    bus(0, 12'h0FC, 0, 0, 2);
    bus(1, 12'h0FC, 1, 0, 2);
    step(0, 16'h1234, 8'h00);
    bus(1, 12'h080, 'h0901, 0, 0);
    lim = 'h900;
    lim_ok = 1'b1;
    @(posedge clk);
    bus(0, 12'h080, 0, 'h900, 0);
    while (sp <= lim + 2)
      step($urandom_range(2), 16'($urandom), 8'($urandom));
    aw <= 4'h5;
    while (sp > 'h7FE) step(3, 0, 0);
    repeat (30) begin
      aw <= 4'($urandom_range(6));
      step(5, 16'($urandom), 0);
    end
    step(5, 16'h0400, 0);
    step(4, 16'h0851, 0);
    step(4, 16'h0700, 0);
    bus(1, 12'h078, 'h0880, 0, 0);
    sp = 'h880;
    bus(0, 12'h078, 0, 'h880, 0);
    bus(0, 12'h100, 0, 3, 0);
    cmp("irq", 0, irq);
    bus(1, 12'h108, 1, 0, 0);
    bus(0, 12'h108, 0, 1, 0);
    cmp("irq", 1, irq);
    bus(1, 12'h104, 3, 0, 0);
    cmp("irq", 0, irq);
    bus(0, 12'h100, 0, 0, 0);
    bus(0, 12'h10C, 0, 0, 0);
    results();
  end
endmodule : tb_top
